// ==== src/pws_pkg.sv ====
package pws_pkg;

  // timing base
  localparam int CLK_PERIOD_NS = 20;
  localparam int GLITCH_NS     = 50;
  localparam int FILT_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC);

  // wiper settling window, least time rounded up
  localparam int SETTLE_MIN_NS  = 5000;
  localparam int SETTLE_MAX_NS  = 10000;
  localparam int SETTLE_CYC_INT = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MAX_CYC = SETTLE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SETTLE_CYC = 9'(SETTLE_CYC_INT);

  // byte framing and register
  localparam int WIPER_W = 7;
  localparam logic [WIPER_W-1:0] WIPER_RESET = 7'h40;
  localparam logic [7:0] REG_INDEX   = 8'h00;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic [1:0] LINE_IDLE   = 2'h3;
  localparam int LINE_SCL = 0;
  localparam int LINE_SDA = 1;

  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_ADDR     = 10'h002,
    ST_ACK_ADDR = 10'h004,
    ST_REG      = 10'h008,
    ST_ACK_REG  = 10'h010,
    ST_WDATA    = 10'h020,
    ST_ACK_DATA = 10'h040,
    ST_TX       = 10'h080,
    ST_MACK     = 10'h100,
    ST_WAIT     = 10'h200
  } pws_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } pws_bus_ev_s;

endpackage

// ==== src/pws_line_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pws_line_filter
  import pws_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] line_in,
  output logic      [1:0] line_out
);

  logic [1:0] sync1_q;
  logic [1:0] sync2_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= LINE_IDLE;
      sync2_q <= LINE_IDLE;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic       filt_q;
      logic       filt_d;
      logic [1:0] cnt_q;
      logic [1:0] cnt_d;

      // a new level must hold one sample longer than the longest glitch
      always_comb begin
        filt_d = filt_q;
        cnt_d  = 2'h0;
        if (sync2_q[g] != filt_q) begin
          if (cnt_q == FILT_LAST) begin
            filt_d = sync2_q[g];
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          filt_q <= 1'b1;
          cnt_q  <= 2'h0;
        end else begin
          filt_q <= filt_d;
          cnt_q  <= cnt_d;
        end
      end

      assign line_out[g] = filt_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== src/pws_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pws_top
  import pws_pkg::*;
#(
  // arbitrary value, set per product
  parameter logic [6:0] DEV_TYPE_ID = 7'h2a
) (
  input  wire logic         REF_CLK_IN,
  input  wire logic         RST_N_IN,
  input  wire logic         SCL_IN,
  input  wire logic         SDA_IN,
  output logic              SDA_OUT,
  output logic              SDA_OE_OUT,
  output logic [WIPER_W-1:0] WIPER_POS_OUT,
  output logic              WIPER_READY_OUT
);

  logic [1:0]  line_f;
  logic [1:0]  prev_q;
  pws_bus_ev_s ev;
  logic        scl_f;
  logic        sda_f;

  pws_line_filter u_filter (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RST_N_IN),
    .line_in  ({SDA_IN, SCL_IN}),
    .line_out (line_f)
  );

  assign scl_f = line_f[LINE_SCL];
  assign sda_f = line_f[LINE_SDA];

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      prev_q <= LINE_IDLE;
    end else begin
      prev_q <= line_f;
    end
  end

  // conditions need the clock high on both samples
  always_comb begin
    ev.start = scl_f & prev_q[LINE_SCL] & prev_q[LINE_SDA] & ~sda_f;
    ev.stop  = scl_f & prev_q[LINE_SCL] & ~prev_q[LINE_SDA] & sda_f;
    ev.rise  = scl_f & ~prev_q[LINE_SCL];
    ev.fall  = ~scl_f & prev_q[LINE_SCL];
  end

  // protocol engine
  pws_state_e        st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        sh_q, sh_d;
  logic              oe_q, oe_d;
  logic              rd_q, rd_d;
  logic              idx_ok_q, idx_ok_d;
  logic              acked_q, acked_d;
  logic [WIPER_W-1:0] wcr_q, wcr_d;
  logic              load;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    oe_d     = oe_q;
    rd_d     = rd_q;
    idx_ok_d = idx_ok_q;
    acked_d  = acked_q;
    wcr_d    = wcr_q;
    load     = 1'b0;
    if (ev.stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (ev.start) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_WAIT: begin
          st_d = st_q;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (ev.rise) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (ev.fall && cnt_q == BYTE_BITS) begin
            cnt_d = 4'h0;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == DEV_TYPE_ID) begin
                oe_d = 1'b1;
                rd_d = (sh_q[0] == DIR_READ);
                st_d = ST_ACK_ADDR;
              end else begin
                st_d = ST_IDLE;
              end
            end else if (st_q == ST_REG) begin
              oe_d     = 1'b1;
              idx_ok_d = (sh_q == REG_INDEX);
              st_d     = ST_ACK_REG;
            end else begin
              oe_d = 1'b1;
              st_d = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (ev.fall) begin
            cnt_d = 4'h0;
            if (rd_q) begin
              sh_d = {1'b0, wcr_q};
              oe_d = 1'b1;
              st_d = ST_TX;
            end else begin
              oe_d = 1'b0;
              st_d = ST_REG;
            end
          end
        end
        ST_ACK_REG, ST_ACK_DATA: begin
          if (ev.fall) begin
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            st_d  = ST_WDATA;
            // commit at the end of the ack clock so the settle wait starts at a finished write
            if (st_q == ST_ACK_DATA && idx_ok_q) begin
              wcr_d = sh_q[WIPER_W-1:0];
              load  = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (ev.rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (ev.fall) begin
            if (cnt_q == BYTE_BITS) begin
              oe_d = 1'b0;
              st_d = ST_MACK;
            end else begin
              oe_d = ~sh_q[6];
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (ev.rise) begin
            acked_d = ~sda_f;
          end else if (ev.fall) begin
            cnt_d = 4'h0;
            if (acked_q) begin
              sh_d = {1'b0, wcr_q};
              oe_d = 1'b1;
              st_d = ST_TX;
            end else begin
              st_d = ST_WAIT;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      oe_q     <= 1'b0;
      rd_q     <= 1'b0;
      idx_ok_q <= 1'b0;
      acked_q  <= 1'b0;
      wcr_q    <= WIPER_RESET;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      oe_q     <= oe_d;
      rd_q     <= rd_d;
      idx_ok_q <= idx_ok_d;
      acked_q  <= acked_d;
      wcr_q    <= wcr_d;
    end
  end

  // wiper settling; a fresh write restarts the wait
  logic [8:0]         settle_q, settle_d;
  logic               pend_q, pend_d;
  logic               ready_q, ready_d;
  logic [WIPER_W-1:0] wiper_q, wiper_d;

  always_comb begin
    settle_d = settle_q;
    pend_d   = pend_q;
    ready_d  = ready_q;
    wiper_d  = wiper_q;
    if (load) begin
      settle_d = SETTLE_CYC;
      pend_d   = 1'b1;
    end else if (pend_q) begin
      if (settle_q == 9'h001) begin
        pend_d  = 1'b0;
        ready_d = 1'b1;
        wiper_d = wcr_q;
      end else begin
        settle_d = settle_q - 9'h001;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      settle_q <= SETTLE_CYC;
      pend_q   <= 1'b1;
      ready_q  <= 1'b0;
      wiper_q  <= WIPER_RESET;
    end else begin
      settle_q <= settle_d;
      pend_q   <= pend_d;
      ready_q  <= ready_d;
      wiper_q  <= wiper_d;
    end
  end

  // open drain: the pin level is only ever pulled low
  logic sda_lvl_q;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sda_lvl_q <= 1'b0;
    end else begin
      sda_lvl_q <= 1'b0;
    end
  end

  assign SDA_OUT         = sda_lvl_q;
  assign SDA_OE_OUT      = oe_q;
  assign WIPER_POS_OUT   = wiper_q;
  assign WIPER_READY_OUT = ready_q;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_addr_end;
    st_q == ST_ADDR && ev.fall && !ev.start && !ev.stop && cnt_q == BYTE_BITS;
  endsequence

  sequence s_tx_end;
    st_q == ST_TX && ev.fall && !ev.start && !ev.stop && cnt_q == BYTE_BITS;
  endsequence

  chk_start_seen: assert property (ev.start && !ev.stop |=> st_q == ST_ADDR)
    else $error("start not taken");
  chk_idle_quiet: assert property (st_q == ST_IDLE |-> !oe_q)
    else $error("driving while idle");
  chk_stop_seen: assert property (ev.stop |=> st_q == ST_IDLE && !oe_q)
    else $error("stop not taken");
  chk_sda_stable: assert property ($changed(oe_q) |-> $past(ev.fall) || $past(ev.stop)
                                   || $past(ev.start))
    else $error("data changed while clock high");
  chk_addr_match: assert property (s_addr_end and (sh_q[7:1] == DEV_TYPE_ID)
                                   |=> oe_q && st_q == ST_ACK_ADDR)
    else $error("matching address not acked");
  chk_addr_miss: assert property (s_addr_end and (sh_q[7:1] != DEV_TYPE_ID)
                                  |=> !oe_q && st_q == ST_IDLE)
    else $error("foreign address acked");
  chk_dir_bit: assert property (s_addr_end and (sh_q[7:1] == DEV_TYPE_ID)
                                |=> rd_q == $past(sh_q[0]))
    else $error("direction bit misdecoded");
  chk_write_ack: assert property (st_q == ST_WDATA && ev.fall && !ev.start && !ev.stop
                                  && cnt_q == BYTE_BITS |=> oe_q ##0 st_q == ST_ACK_DATA)
    else $error("write byte not acked");
  chk_tx_release: assert property (s_tx_end |=> !oe_q && st_q == ST_MACK)
    else $error("line not released for master ack");
  chk_nack_wait: assert property (st_q == ST_MACK && ev.fall && !acked_q && !ev.start
                                  && !ev.stop |=> st_q == ST_WAIT [*2] ##0 !oe_q)
    else $error("kept sending after no-ack");
  chk_msb_zero: assert property (st_q == ST_ACK_ADDR && rd_q && ev.fall && !ev.start
                                 && !ev.stop |=> oe_q && sh_q[7] == 1'b0)
    else $error("read msb not zero");
  chk_settle_time: assert property ($changed(wiper_q) |-> $past(settle_q) == 9'h001
                                    && $past(pend_q))
    else $error("wiper moved outside settle window");
  chk_load_hold: assert property (load |=> $stable(wiper_q) [*8])
    else $error("wiper moved too early");

endmodule
`default_nettype wire

// ==== verification/pws_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module pws_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  // 3 clocks; bus period 300 ns, the slave answers ~7 clocks after a fall
  task automatic q();
    repeat (3) @(posedge clk_in);
  endtask
  task automatic start();
    sda_oe_out <= 1'b0;
    q();
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_out <= 1'b1;
    q();
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b0;
    // bus left idle so a following start or pulse cannot merge into the stop
    q();
    q();
  endtask
  // 40 ns pulse, then clock parked low with data high
  task automatic glitch();
    sda_oe_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    sda_oe_out <= 1'b0;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic bit_io(input logic pull, output logic seen);
    sda_oe_out <= pull;
    q();
    q();
    scl_out <= 1'b1;
    q();
    seen = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic m_ack,
                         output logic [7:0] rx, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~tx[i], s);
      rx[i] = s;
    end
    bit_io(m_ack, s);
    acked = ~s;
  endtask
endmodule
`default_nettype wire

// ==== verification/test_pws_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_pws_top;
  import pws_pkg::*;
  // arbitrary identifier value
  localparam logic [6:0] DEV_ID = 7'h2a;
  logic               ref_clk;
  logic               rst_n;
  logic               scl;
  wire logic          sda;
  logic               m_oe;
  logic               sda_out;
  logic               sda_oe;
  logic [WIPER_W-1:0] wiper;
  logic               ready;
  int                 num_errors = 0;
  int                 n_compared = 0;

  // open drain with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & ~m_oe;

  pws_top #(.DEV_TYPE_ID(DEV_ID)) dut (
    .REF_CLK_IN      (ref_clk),
    .RST_N_IN        (rst_n),
    .SCL_IN          (scl),
    .SDA_IN          (sda),
    .SDA_OUT         (sda_out),
    .SDA_OE_OUT      (sda_oe),
    .WIPER_POS_OUT   (wiper),
    .WIPER_READY_OUT (ready)
  );
  pws_bus_master m (
    .clk_in     (ref_clk),
    .sda_in     (sda),
    .scl_out    (scl),
    .sda_oe_out (m_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_reset();
    @(posedge ref_clk);
    check("wiper rst", {1'b0, wiper}, 8'h40);
    check("ready rst", {7'h0, ready}, 8'h00);
    repeat (238) @(posedge ref_clk);
    check("ready early", {7'h0, ready}, 8'h00);
    repeat (SETTLE_MAX_CYC - 249) @(posedge ref_clk);
    check("ready late", {7'h0, ready}, 8'h01);
    check("wiper pwr", {1'b0, wiper}, 8'h40);
  endtask

  task automatic wr_hdr();
    logic [7:0] rx;
    logic       a;
    m.start();
    m.byte_io({DEV_ID, 1'b0}, 1'b0, rx, a);
    check("addr w ack", {7'h0, a}, 8'h01);
    m.byte_io(8'h00, 1'b0, rx, a);
    check("index ack", {7'h0, a}, 8'h01);
  endtask

  // two data bytes back to back: the second reloads and restarts the wait
  task automatic t_write();
    logic [7:0] rx;
    logic       a;
    wr_hdr();
    m.byte_io(8'hd5, 1'b0, rx, a);
    check("data1 ack", {7'h0, a}, 8'h01);
    m.byte_io(8'hab, 1'b0, rx, a);
    check("data2 ack", {7'h0, a}, 8'h01);
    m.stop();
    // ack clock fell 3 cycles before stop began; stop takes 15 cycles
    repeat (SETTLE_CYC_INT - 19) @(posedge ref_clk);
    check("wiper early", {1'b0, wiper}, 8'h40);
    repeat (SETTLE_MAX_CYC - SETTLE_CYC_INT + 1) @(posedge ref_clk);
    check("wiper late", {1'b0, wiper}, 8'h2b);
  endtask

  task automatic t_read();
    logic [7:0] rx;
    logic       a;
    wr_hdr();
    m.start();
    m.byte_io({DEV_ID, 1'b1}, 1'b0, rx, a);
    check("addr r ack", {7'h0, a}, 8'h01);
    m.byte_io(8'hff, 1'b1, rx, a);
    check("read 1", rx, 8'h2b);
    m.byte_io(8'hff, 1'b0, rx, a);
    check("read 2", rx, 8'h2b);
    m.byte_io(8'hff, 1'b0, rx, a);
    check("after nack", rx, 8'hff);
    m.stop();
  endtask

  task automatic t_wrong_id();
    logic [7:0] rx;
    logic       a;
    for (int k = 0; k < 7; k++) begin
      m.start();
      m.byte_io({DEV_ID ^ (7'h01 << k), 1'b0}, 1'b0, rx, a);
      check("foreign ack", {7'h0, a}, 8'h00);
      m.byte_io(8'h00, 1'b0, rx, a);
      check("foreign data", {7'h0, a}, 8'h00);
      m.stop();
    end
  endtask

  // short pulse must not count as a start, so the address goes unanswered
  task automatic t_glitch();
    logic [7:0] rx;
    logic       a;
    m.glitch();
    m.byte_io({DEV_ID, 1'b0}, 1'b0, rx, a);
    check("no start ack", {7'h0, a}, 8'h00);
    m.stop();
    check("wiper kept", {1'b0, wiper}, 8'h2b);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_wrong_id();
    t_glitch();
    report_and_stop();
  end
endmodule
`default_nettype wire
